/* shared/svc_link_pkg.sv */
// Constants shared by the service and link parameter command block
package svc_link_pkg;
    // Command codes presented on cmdCode
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_SET_SERVICES = 3'h1;
    localparam logic [2:0] CMD_SET_CONN = 3'h2;
    localparam logic [2:0] CMD_GET_CONN = 3'h3;
    localparam logic [2:0] CMD_ECHO_TOGGLE = 3'h4;
    localparam logic [2:0] CMD_ANALOG_OUT = 3'h5;
    localparam logic [2:0] CMD_ANALOG_IN = 3'h6;
    // Service bitmap positions and reset value
    localparam int SVC_DEVICE_INFO_BIT = 31;
    localparam int SVC_HEART_RATE_BIT = 29;
    localparam int SVC_SCAN_PARAM_BIT = 14;
    localparam int SVC_PRIVATE_BIT = 0;
    localparam logic [31:0] SVC_RESET = 32'h80000000;
    // Feature bit that turns on strict parameter checking
    localparam int FEAT_STRICT_BIT = 14;
    // Connection parameter ranges and defaults
    localparam logic [15:0] INTERVAL_MIN = 16'h0006;
    localparam logic [15:0] INTERVAL_MAX = 16'h0c80;
    localparam logic [15:0] INTERVAL_DEF = 16'h0006;
    localparam logic [15:0] LATENCY_MAX = 16'h01f3;
    localparam logic [15:0] LATENCY_DEF = 16'h0000;
    localparam logic [15:0] TIMEOUT_MIN = 16'h000a;
    localparam logic [15:0] TIMEOUT_MAX = 16'h0c80;
    localparam logic [15:0] TIMEOUT_DEF = 16'h0064;
    // Strict-mode limits
    localparam logic [15:0] STRICT_INTERVAL_MIN = 16'h0010;
    localparam logic [15:0] STRICT_LATENCY_MAX = 16'h0004;
    localparam logic [15:0] STRICT_TIMEOUT_MAX = 16'h0258;
    localparam logic [15:0] STRICT_INTERVAL_ADD = 16'h0010;
    // Analog ports and value range in millivolts
    localparam logic [1:0] ANALOG_PORT_MAX = 2'h2;
    localparam int ANALOG_PORTS = 3;
    localparam logic [15:0] ANALOG_MV_MAX = 16'h0514;
    // Sleep modes
    typedef enum logic [1:0] {
        SLEEP_NONE = 2'h0,
        SLEEP_SHALLOW = 2'h1,
        SLEEP_DEEP = 2'h2
    } sleep_e;
    // Command engine states, Gray from ST_IDLE to ST_CHECK to ST_REPLY
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHECK = 2'b01,
        ST_REPLY = 2'b11
    } cmd_state_e;
endpackage

/* src/conn_param_check.sv */
// Range and relation check of a set of connection parameters
`timescale 1ns/100ps
module conn_param_check (
    input wire logic [15:0] interval,
    input wire logic [15:0] latency,
    input wire logic [15:0] timeout,
    input wire logic strictMode,
    output logic paramsOk
);
    logic baseOk;
    logic relOk;
    logic strictOk;
    logic [35:0] lhsBase;
    logic [35:0] rhsBase;
    logic [35:0] lhsStrict;
    logic [35:0] rhsStrict;

    // Base ranges: latency < timeout*10/(interval*1.25) - 1, scaled to
    // integers as interval*(latency+1) < 8*timeout. Scaling avoids a
    // divider at the cost of wider products.
    always_comb begin
        baseOk = (interval >= svc_link_pkg::INTERVAL_MIN) &&
            (interval <= svc_link_pkg::INTERVAL_MAX) &&
            (latency <= svc_link_pkg::LATENCY_MAX) &&
            (timeout >= svc_link_pkg::TIMEOUT_MIN) &&
            (timeout <= svc_link_pkg::TIMEOUT_MAX);
        lhsBase = 36'({20'h0, interval} * {20'h0, latency + 16'h0001});
        rhsBase = 36'({20'h0, timeout} * 36'h8);
        relOk = lhsBase < rhsBase;
    end

    // Strict mode: (interval+16)*(latency+1)*3 < timeout*8
    always_comb begin
        lhsStrict = 36'({20'h0, interval + svc_link_pkg::STRICT_INTERVAL_ADD}
            * {20'h0, latency + 16'h0001} * 36'h3);
        rhsStrict = 36'({20'h0, timeout} * 36'h8);
        strictOk = (interval >= svc_link_pkg::STRICT_INTERVAL_MIN) &&
            (latency <= svc_link_pkg::STRICT_LATENCY_MAX) &&
            (timeout <= svc_link_pkg::STRICT_TIMEOUT_MAX) &&
            (lhsStrict < rhsStrict);
        paramsOk = baseOk && relOk && (!strictMode || strictOk);
    end
endmodule // conn_param_check

/* src/analog_sleep_ctrl.sv */
// Analog output levels per port and the sleep mode they allow
`timescale 1ns/100ps
module analog_sleep_ctrl (
    input wire logic clock,
    input wire logic rst,
    input wire logic writeEn,
    input wire logic [1:0] writePort,
    input wire logic [15:0] writeMv,
    input wire logic sleepRequest,
    output logic [47:0] analogOutMv,
    output logic analogActive,
    output svc_link_pkg::sleep_e sleepMode
);
    logic [15:0] levelQ [svc_link_pkg::ANALOG_PORTS];
    logic [2:0] activeBits;

    // One register per port; a zero write turns that port off
    for (genvar p = 0; p < svc_link_pkg::ANALOG_PORTS; p++) begin : g_port
        always_ff @(posedge clock) begin
            if (rst) begin
                levelQ[p] <= 16'h0000;
            end else if (writeEn && writePort == 2'(p)) begin
                levelQ[p] <= writeMv;
            end
        end
        assign activeBits[p] = levelQ[p] != 16'h0000;
        assign analogOutMv[16*p +: 16] = levelQ[p];
    end

    assign analogActive = |activeBits;

    // Deep sleep is barred while any output drives, shallow used instead
    always_ff @(posedge clock) begin
        if (rst) begin
            sleepMode <= svc_link_pkg::SLEEP_NONE;
        end else if (!sleepRequest) begin
            sleepMode <= svc_link_pkg::SLEEP_NONE;
        end else if (analogActive) begin
            sleepMode <= svc_link_pkg::SLEEP_SHALLOW;
        end else begin
            sleepMode <= svc_link_pkg::SLEEP_DEEP;
        end
    end

    AST_NO_DEEP_WHILE_ACTIVE: assert property (@(posedge clock) disable iff
        (rst) analogActive && sleepRequest |=>
        sleepMode == svc_link_pkg::SLEEP_SHALLOW)
        else $error("deep sleep chosen with analog output active");
    AST_DEEP_AFTER_OFF: assert property (@(posedge clock) disable iff (rst)
        !analogActive && sleepRequest |=>
        sleepMode == svc_link_pkg::SLEEP_DEEP)
        else $error("deep sleep not restored after analog off");
endmodule // analog_sleep_ctrl

/* src/service_link_cmd.sv */
// Command interpreter for services, link parameters, echo and analog
`timescale 1ns/100ps
// Functional notes
// - Set-services command takes one 32-bit bitmap, one bit per service.
// - New service bitmap takes effect only after a restart.
// - Bit 31 device info, bit 29 heart rate, bit 14 scan parameters.
// - Bit 0 enables the user-defined private service.
// - Set-connection takes interval, latency, timeout, 16 bits each.
// - Central connects with stored values; peripheral requests an update.
// - Get reports stored values when idle, live values when connected.
// - Interval 0x0006..0x0C80 in 1.25 ms steps, default 0006.
// - Latency 0..0x01F3 and below timeout*10/(interval*1.25)-1.
// - Timeout 0x000A..0x0C80 in 10 ms units, default 0064.
// - Strict mode adds interval, latency, timeout and product limits.
// - Each echo-toggle in command mode inverts echo, starting off.
// - Analog port number must be 0, 1 or 2.
// - Analog values in mV, valid 0x0000 to 0x0514.
// - Active analog output forbids deep sleep, shallow used instead.
// - Writing 0000 to analog output lets deep sleep return.
// - Strict checking enabled by feature bitmap bit 14.
module service_link_cmd (
    input wire logic clock,
    input wire logic rst,
    // Command port
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [2:0] cmdCode,
    input wire logic [31:0] cmdArg0,
    input wire logic [15:0] cmdArg1,
    input wire logic [15:0] cmdArg2,
    input wire logic commandMode,
    output logic respValid,
    output logic respError,
    output logic [47:0] respData,
    // Configuration and status
    input wire logic [31:0] featureBitmap,
    input wire logic isCentral,
    input wire logic connected,
    input wire logic [15:0] liveInterval,
    input wire logic [15:0] liveLatency,
    input wire logic [15:0] liveTimeout,
    output logic [31:0] storedServices,
    output logic [31:0] activeServices,
    output logic deviceInfoSvc,
    output logic heartRateSvc,
    output logic scanParamSvc,
    output logic privateSvc,
    output logic [15:0] connInterval,
    output logic [15:0] connLatency,
    output logic [15:0] connTimeout,
    output logic connectReq,
    output logic updateReq,
    // Echo path
    input wire logic rxCharValid,
    input wire logic [7:0] rxChar,
    output logic echoOn,
    output logic echoValid,
    output logic [7:0] echoChar,
    // Analog and sleep
    input wire logic [15:0] analogInMv,
    input wire logic sleepRequest,
    output logic [47:0] analogOutMv,
    output svc_link_pkg::sleep_e sleepMode
);
    svc_link_pkg::cmd_state_e state_q;
    logic [2:0] code_q;
    logic [31:0] arg0_q;
    logic [15:0] arg1_q;
    logic [15:0] arg2_q;
    logic paramsOk;
    logic strictMode;
    logic cmdOk;
    logic analogWrite;
    logic connected_q;
    logic analogActive;

    // Validity of a port number, used by both analog commands
    function automatic logic portOk(input logic [31:0] arg);
        return arg <= 32'(svc_link_pkg::ANALOG_PORT_MAX);
    endfunction

    assign strictMode = featureBitmap[svc_link_pkg::FEAT_STRICT_BIT];

    conn_param_check u_check (
        .interval(arg0_q[15:0]),
        .latency(arg1_q),
        .timeout(arg2_q),
        .strictMode(strictMode),
        .paramsOk(paramsOk)
    );

    // Per-command acceptance; any failure keeps old state
    always_comb begin
        unique case (code_q)
            svc_link_pkg::CMD_SET_SERVICES: cmdOk = 1'b1;
            svc_link_pkg::CMD_SET_CONN: cmdOk = paramsOk;
            svc_link_pkg::CMD_GET_CONN: cmdOk = 1'b1;
            svc_link_pkg::CMD_ECHO_TOGGLE: cmdOk = 1'b1;
            svc_link_pkg::CMD_ANALOG_OUT: cmdOk = portOk(arg0_q) &&
                (arg1_q <= svc_link_pkg::ANALOG_MV_MAX);
            svc_link_pkg::CMD_ANALOG_IN: cmdOk = portOk(arg0_q);
            default: cmdOk = 1'b0; // Unknown codes answer with error
        endcase
    end

    assign cmdReady = state_q == svc_link_pkg::ST_IDLE;
    assign analogWrite = state_q == svc_link_pkg::ST_CHECK &&
        code_q == svc_link_pkg::CMD_ANALOG_OUT && cmdOk;

    // Capture, check, reply: one command in flight
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= svc_link_pkg::ST_IDLE;
            code_q <= svc_link_pkg::CMD_NONE;
            arg0_q <= 32'h00000000;
            arg1_q <= 16'h0000;
            arg2_q <= 16'h0000;
        end else begin
            unique case (state_q)
                svc_link_pkg::ST_IDLE: begin
                    if (cmdValid) begin
                        code_q <= cmdCode;
                        arg0_q <= cmdArg0;
                        arg1_q <= cmdArg1;
                        arg2_q <= cmdArg2;
                        state_q <= svc_link_pkg::ST_CHECK;
                    end
                end
                svc_link_pkg::ST_CHECK: state_q <= svc_link_pkg::ST_REPLY;
                svc_link_pkg::ST_REPLY: state_q <= svc_link_pkg::ST_IDLE;
                default: state_q <= svc_link_pkg::ST_IDLE;
            endcase
        end
    end

    // Response word, valid for the one cycle in ST_REPLY
    always_ff @(posedge clock) begin
        if (rst) begin
            respError <= 1'b0;
            respData <= 48'h000000000000;
        end else if (state_q == svc_link_pkg::ST_CHECK) begin
            respError <= !cmdOk;
            respData <= 48'h000000000000;
            if (cmdOk && code_q == svc_link_pkg::CMD_GET_CONN) begin
                respData <= connected ?
                    {liveInterval, liveLatency, liveTimeout} :
                    {connInterval, connLatency, connTimeout};
            end else if (cmdOk && code_q == svc_link_pkg::CMD_ANALOG_IN) begin
                respData <= {32'h00000000, analogInMv};
            end
        end
    end
    assign respValid = state_q == svc_link_pkg::ST_REPLY;

    // Stored bitmap is written now; the offered set only at reset/restart
    always_ff @(posedge clock) begin
        if (rst) begin
            storedServices <= svc_link_pkg::SVC_RESET;
        end else if (state_q == svc_link_pkg::ST_CHECK && cmdOk &&
                code_q == svc_link_pkg::CMD_SET_SERVICES) begin
            storedServices <= arg0_q;
        end
    end
    // A register with no reset of its own loads storedServices on rst, before
    // rst reloads storedServices with SVC_RESET; rst is the restart that applies it.
    always_ff @(posedge clock) begin
        if (rst) begin
            activeServices <= storedServices;
        end
    end
    assign deviceInfoSvc = activeServices[svc_link_pkg::SVC_DEVICE_INFO_BIT];
    assign heartRateSvc = activeServices[svc_link_pkg::SVC_HEART_RATE_BIT];
    assign scanParamSvc = activeServices[svc_link_pkg::SVC_SCAN_PARAM_BIT];
    assign privateSvc = activeServices[svc_link_pkg::SVC_PRIVATE_BIT];

    // Desired connection parameters, only replaced by a checked set
    always_ff @(posedge clock) begin
        if (rst) begin
            connInterval <= svc_link_pkg::INTERVAL_DEF;
            connLatency <= svc_link_pkg::LATENCY_DEF;
            connTimeout <= svc_link_pkg::TIMEOUT_DEF;
        end else if (state_q == svc_link_pkg::ST_CHECK && cmdOk &&
                code_q == svc_link_pkg::CMD_SET_CONN) begin
            connInterval <= arg0_q[15:0];
            connLatency <= arg1_q;
            connTimeout <= arg2_q;
        end
    end

    // On a new link a peripheral asks for an update with stored values;
    // a central uses them when it connects, flagged by connectReq
    always_ff @(posedge clock) begin
        if (rst) begin
            connected_q <= 1'b0;
            updateReq <= 1'b0;
        end else begin
            connected_q <= connected;
            updateReq <= connected && !connected_q && !isCentral;
        end
    end
    assign connectReq = isCentral && !connected;

    // Echo toggles only for commands taken in command mode
    always_ff @(posedge clock) begin
        if (rst) begin
            echoOn <= 1'b0;
        end else if (cmdValid && cmdReady && commandMode &&
                cmdCode == svc_link_pkg::CMD_ECHO_TOGGLE) begin
            echoOn <= !echoOn;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            echoValid <= 1'b0;
            echoChar <= 8'h00;
        end else begin
            echoValid <= rxCharValid && echoOn;
            echoChar <= rxChar;
        end
    end

    analog_sleep_ctrl u_analog (
        .clock(clock),
        .rst(rst),
        .writeEn(analogWrite),
        .writePort(arg0_q[1:0]),
        .writeMv(arg1_q),
        .sleepRequest(sleepRequest),
        .analogOutMv(analogOutMv),
        .analogActive(analogActive),
        .sleepMode(sleepMode)
    );

    AST_BAD_CONN_KEPT: assert property (@(posedge clock) disable iff (rst)
        state_q == svc_link_pkg::ST_CHECK && !cmdOk |=>
        $stable(connInterval) && respError && respValid)
        else $error("rejected command changed state or gave no error");
    AST_REPLY_TIMING: assert property (@(posedge clock) disable iff (rst)
        cmdValid && cmdReady |=> !respValid ##1 respValid ##1 cmdReady)
        else $error("reply not two cycles after command");
    AST_SVC_DEFERRED: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> $stable(activeServices))
        else $error("active services changed without restart");
    AST_ECHO_TOGGLE: assert property (@(posedge clock) disable iff (rst)
        cmdValid && cmdReady && commandMode &&
        cmdCode == svc_link_pkg::CMD_ECHO_TOGGLE |=> echoOn != $past(echoOn))
        else $error("echo did not toggle");
    AST_ECHO_CHAR: assert property (@(posedge clock) disable iff (rst)
        rxCharValid && echoOn |=> echoValid && echoChar == $past(rxChar))
        else $error("typed character not echoed");
    AST_GET_LIVE: assert property (@(posedge clock) disable iff (rst)
        state_q == svc_link_pkg::ST_CHECK && connected &&
        code_q == svc_link_pkg::CMD_GET_CONN |=>
        respData[47:32] == $past(liveInterval))
        else $error("live interval not reported");
    AST_PORT_RANGE: assert property (@(posedge clock) disable iff (rst)
        state_q == svc_link_pkg::ST_CHECK && arg0_q > 32'h2 &&
        code_q == svc_link_pkg::CMD_ANALOG_IN |=> respError)
        else $error("bad analog port accepted");
    AST_MV_RANGE: assert property (@(posedge clock) disable iff (rst)
        analogWrite |-> arg1_q <= 16'h0514)
        else $error("analog value above range written");
    AST_UPDATE_REQ: assert property (@(posedge clock) disable iff (rst)
        $rose(connected) && !isCentral |=> updateReq)
        else $error("peripheral did not request update");
endmodule // service_link_cmd

/* testbench/host_cmd_model.sv */
// Host controller model that issues commands on the command port
`timescale 1ns/100ps
module host_cmd_model (
    input wire logic clock,
    input wire logic cmdReady,
    input wire logic respValid,
    input wire logic respError,
    input wire logic [47:0] respData,
    output logic cmdValid,
    output logic [2:0] cmdCode,
    output logic [31:0] cmdArg0,
    output logic [15:0] cmdArg1,
    output logic [15:0] cmdArg2
);
    // Idle bus at time zero
    initial begin
        cmdValid = 1'b0;
        cmdCode = 3'h0;
        cmdArg0 = 32'h0;
        cmdArg1 = 16'h0;
        cmdArg2 = 16'h0;
    end

    // One command: hold until taken, then wait for the single-cycle answer
    task automatic issue(input logic [2:0] code, input logic [31:0] a0,
            input logic [15:0] a1, input logic [15:0] a2,
            output logic err, output logic [47:0] data);
        int n;
        n = 0;
        cmdValid = 1'b1;
        cmdCode = code;
        cmdArg0 = a0;
        cmdArg1 = a1;
        cmdArg2 = a2;
        while (cmdReady !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        @(negedge clock);
        // Released fields show garbage, so a late sample cannot pass
        cmdValid = 1'b0;
        cmdCode = ~cmdCode;
        cmdArg0 = ~cmdArg0;
        cmdArg1 = ~cmdArg1;
        cmdArg2 = ~cmdArg2;
        n = 0;
        while (respValid !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        err = respError;
        data = respData;
        // A missing answer leaves an unknown error flag, so the check fails
        if (n >= 50) begin
            err = 1'bx;
        end
        @(negedge clock);
    endtask
endmodule // host_cmd_model

/* testbench/tb_service_and_link_param_commands.sv */
// Self-checking bench for the service and link parameter commands
`timescale 1ns/100ps
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin \
    failures++; $display("Error at %0t: got %h expected %h", \
    $time, got, exp); end end
module tb_service_and_link_param_commands;
    typedef struct packed {
        logic [2:0] code;
        logic [31:0] a0;
        logic [15:0] a1;
        logic [15:0] a2;
        logic strict;
        logic err;
        logic [47:0] data;
    } row_s;
    logic clock = 1'b0, rst = 1'b1, cmdValid, cmdReady, commandMode = 1'b0;
    logic [2:0] cmdCode;
    logic [31:0] cmdArg0, featureBitmap = 32'h0;
    logic [15:0] cmdArg1, cmdArg2, connInterval, connLatency, connTimeout;
    logic respValid, respError, isCentral = 1'b0, connected = 1'b0;
    logic [47:0] respData, analogOutMv;
    logic [15:0] liveInterval = 16'h0020, liveLatency = 16'h0001;
    logic [15:0] liveTimeout = 16'h0100, analogInMv = 16'h0514;
    logic [31:0] storedServices, activeServices;
    logic deviceInfoSvc, heartRateSvc, scanParamSvc, privateSvc;
    logic connectReq, updateReq, rxCharValid = 1'b0, echoOn, echoValid;
    logic [7:0] rxChar = 8'h00, echoChar;
    logic sleepRequest = 1'b1, err;
    logic [47:0] data;
    svc_link_pkg::sleep_e sleepMode;
    int failures = 0, nChecks = 0, cycles = 0, cnt;
    // Ordinary cases: ranges, relations, strict limits, codes
    row_s rows [25] = '{
        '{3'h1, 32'h20004001, 16'h0, 16'h0, 1'b0, 1'b0, 48'h0},
        '{3'h2, 32'h00000064, 16'h0002, 16'h0064, 1'b0, 1'b0, 48'h0},
        '{3'h3, 32'h0, 16'h0, 16'h0, 1'b0, 1'b0, 48'h0064_0002_0064},
        '{3'h2, 32'h00000006, 16'h0000, 16'h000a, 1'b0, 1'b0, 48'h0},
        '{3'h2, 32'h00000005, 16'h0000, 16'h0064, 1'b0, 1'b1, 48'h0},
        '{3'h2, 32'h00000c81, 16'h0000, 16'h0064, 1'b0, 1'b1, 48'h0},
        '{3'h2, 32'h00000006, 16'h01f4, 16'h0c80, 1'b0, 1'b1, 48'h0},
        '{3'h2, 32'h00000006, 16'h0000, 16'h0009, 1'b0, 1'b1, 48'h0},
        '{3'h2, 32'h00000006, 16'h0000, 16'h0c81, 1'b0, 1'b1, 48'h0},
        '{3'h2, 32'h00000064, 16'h0003, 16'h000a, 1'b0, 1'b1, 48'h0},
        '{3'h3, 32'h0, 16'h0, 16'h0, 1'b0, 1'b0, 48'h0006_0000_000a},
        '{3'h2, 32'h0000000f, 16'h0000, 16'h0064, 1'b1, 1'b1, 48'h0},
        '{3'h2, 32'h00000100, 16'h0004, 16'h01fe, 1'b1, 1'b1, 48'h0},
        '{3'h2, 32'h00000010, 16'h0005, 16'h0064, 1'b1, 1'b1, 48'h0},
        '{3'h2, 32'h00000010, 16'h0000, 16'h0259, 1'b1, 1'b1, 48'h0},
        '{3'h2, 32'h00000100, 16'h0004, 16'h0200, 1'b1, 1'b0, 48'h0},
        '{3'h3, 32'h0, 16'h0, 16'h0, 1'b1, 1'b0, 48'h0100_0004_0200},
        '{3'h2, 32'h00000006, 16'h01f3, 16'h0c80, 1'b0, 1'b0, 48'h0},
        '{3'h2, 32'h00000c80, 16'h0000, 16'h0c80, 1'b0, 1'b0, 48'h0},
        '{3'h3, 32'h0, 16'h0, 16'h0, 1'b0, 1'b0, 48'h0c80_0000_0c80},
        '{3'h6, 32'h00000002, 16'h0, 16'h0, 1'b0, 1'b0, 48'h0514},
        '{3'h6, 32'h00000003, 16'h0, 16'h0, 1'b0, 1'b1, 48'h0},
        '{3'h5, 32'h00000003, 16'h0100, 16'h0, 1'b0, 1'b1, 48'h0},
        '{3'h5, 32'h00000000, 16'h0515, 16'h0, 1'b0, 1'b1, 48'h0},
        '{3'h7, 32'h0, 16'h0, 16'h0, 1'b0, 1'b1, 48'h0}
    };

    always #10 clock = ~clock;

    service_link_cmd service_link_cmd_inst (.clock(clock), .rst(rst),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdCode(cmdCode),
        .cmdArg0(cmdArg0), .cmdArg1(cmdArg1), .cmdArg2(cmdArg2),
        .commandMode(commandMode), .respValid(respValid),
        .respError(respError), .respData(respData),
        .featureBitmap(featureBitmap), .isCentral(isCentral),
        .connected(connected), .liveInterval(liveInterval),
        .liveLatency(liveLatency), .liveTimeout(liveTimeout),
        .storedServices(storedServices), .activeServices(activeServices),
        .deviceInfoSvc(deviceInfoSvc), .heartRateSvc(heartRateSvc),
        .scanParamSvc(scanParamSvc), .privateSvc(privateSvc),
        .connInterval(connInterval), .connLatency(connLatency),
        .connTimeout(connTimeout), .connectReq(connectReq),
        .updateReq(updateReq), .rxCharValid(rxCharValid), .rxChar(rxChar),
        .echoOn(echoOn), .echoValid(echoValid), .echoChar(echoChar),
        .analogInMv(analogInMv), .sleepRequest(sleepRequest),
        .analogOutMv(analogOutMv), .sleepMode(sleepMode));

    host_cmd_model host_cmd_model_inst (.clock(clock), .cmdReady(cmdReady),
        .respValid(respValid), .respError(respError), .respData(respData),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdArg0(cmdArg0),
        .cmdArg1(cmdArg1), .cmdArg2(cmdArg2));

    // Verdict and end of run
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles; hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic cmd(input logic [2:0] c, input logic [31:0] a0,
            input logic [15:0] a1);
        host_cmd_model_inst.issue(c, a0, a1, 16'h0, err, data);
    endtask

    initial begin
        repeat (10) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        `CHK(connInterval, 16'h0006)
        `CHK(connLatency, 16'h0000)
        `CHK(connTimeout, 16'h0064)
        `CHK(activeServices, 32'h80000000)
        `CHK(sleepMode, svc_link_pkg::SLEEP_DEEP)
        foreach (rows[i]) begin
            featureBitmap = rows[i].strict ? 32'h00004000 : 32'h0;
            host_cmd_model_inst.issue(rows[i].code, rows[i].a0, rows[i].a1,
                rows[i].a2, err, data);
            `CHK(err, rows[i].err)
            if (!rows[i].err) `CHK(data, rows[i].data)
        end
        `CHK(analogOutMv, 48'h0)
        // Bitmap stays latent until the restart applies it
        `CHK(storedServices, 32'h20004001)
        `CHK(activeServices, 32'h80000000)
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        `CHK(activeServices, 32'h20004001)
        `CHK({deviceInfoSvc, heartRateSvc, scanParamSvc}, 3'h3)
        `CHK(privateSvc, 1'b1)
        // Live values reported only while connected
        isCentral = 1'b1;
        @(negedge clock);
        `CHK(connectReq, 1'b1)
        connected = 1'b1;
        cmd(svc_link_pkg::CMD_GET_CONN, 32'h0, 16'h0);
        `CHK(data, 48'h0020_0001_0100)
        `CHK(connectReq, 1'b0)
        isCentral = 1'b0;
        connected = 1'b0;
        @(negedge clock);
        connected = 1'b1;
        cnt = 0;
        repeat (3) begin
            @(negedge clock);
            if (updateReq === 1'b1) cnt++;
        end
        `CHK(cnt, 1)
        // Echo toggles only in command mode
        cmd(svc_link_pkg::CMD_ECHO_TOGGLE, 32'h0, 16'h0);
        `CHK(echoOn, 1'b0)
        commandMode = 1'b1;
        cmd(svc_link_pkg::CMD_ECHO_TOGGLE, 32'h0, 16'h0);
        `CHK(echoOn, 1'b1)
        rxCharValid = 1'b1;
        rxChar = 8'h41;
        @(negedge clock);
        rxCharValid = 1'b0;
        `CHK({echoValid, echoChar}, 9'h141)
        cmd(svc_link_pkg::CMD_ECHO_TOGGLE, 32'h0, 16'h0);
        `CHK(echoOn, 1'b0)
        // Analog output forces shallow sleep until written back to zero
        cmd(svc_link_pkg::CMD_ANALOG_OUT, 32'h1, 16'h03e8);
        `CHK(err, 1'b0)
        @(negedge clock);
        `CHK(analogOutMv, 48'h0000_03e8_0000)
        `CHK(sleepMode, svc_link_pkg::SLEEP_SHALLOW)
        cmd(svc_link_pkg::CMD_ANALOG_OUT, 32'h1, 16'h0000);
        @(negedge clock);
        `CHK(sleepMode, svc_link_pkg::SLEEP_DEEP)
        print_verdict();
    end
endmodule // tb_service_and_link_param_commands
